// ==== nfh_params.svh ====
// Purpose: Constants of the NAND host command sequencer.
// Assumes: 100 MHz CLK_I; x8 bus; addresses sent low byte first.
// Notes:   Times are printed figures; cycle counts derive from them.
`ifndef NFH_PARAMS_SVH
`define NFH_PARAMS_SVH

// ==========================================================
// Clock and times
`define NFH_CLK_MHZ        100
`define NFH_T_POWERUP_US   100
`define NFH_T_RST_MS       1
`define NFH_T_WB_NS        100
`define NFH_T_WHR_NS       60
`define NFH_POWERUP_CYC    (`NFH_T_POWERUP_US * `NFH_CLK_MHZ)
`define NFH_RST_CYC        (`NFH_T_RST_MS * 1000 * `NFH_CLK_MHZ)
`define NFH_WB_CYC         ((`NFH_T_WB_NS * `NFH_CLK_MHZ + 999) / 1000)
`define NFH_WHR_CYC        ((`NFH_T_WHR_NS * `NFH_CLK_MHZ + 999) / 1000)
`define NFH_TMR_W          17

// ==========================================================
// Strobe phases: two cycles low, two cycles high
`define NFH_PH_RISE        2'h1
`define NFH_PH_LAST        2'h3

// ==========================================================
// Opcodes
`define NFH_OP_RESET       8'hFF
`define NFH_OP_STATUS      8'h70
`define NFH_OP_STATUS_ENH  8'h78
`define NFH_OP_READ_ID     8'h90
`define NFH_OP_PARAM       8'hEC
`define NFH_OP_UID         8'hED
`define NFH_OP_GET_FEAT    8'hEE
`define NFH_OP_SET_FEAT    8'hEF
`define NFH_OP_READ        8'h00
`define NFH_OP_READ_GO     8'h30
`define NFH_OP_CACHE_SEQ   8'h31
`define NFH_OP_CACHE_LAST  8'h3F
`define NFH_OP_MOVE_RD     8'h35
`define NFH_OP_RAND_RD     8'h05
`define NFH_OP_RAND_RD2    8'h06
`define NFH_OP_RAND_IN     8'h85
`define NFH_OP_PROG        8'h80
`define NFH_OP_PROG_GO     8'h10
`define NFH_OP_PROG_CACHE  8'h15
`define NFH_OP_PLANE_PROG  8'h11
`define NFH_OP_ERASE       8'h60
`define NFH_OP_PLANE_ERASE 8'hD1
`define NFH_OP_UNLOCK_LO   8'h23
`define NFH_OP_UNLOCK_HI   8'h24
`define NFH_OP_LOCK_RD     8'h7A

// ==========================================================
// Status and identifier fields
`define NFH_STAT_RST_WP1   8'hE0
`define NFH_STAT_RST_WP0   8'h60
`define NFH_STAT_RDY       6
`define NFH_STAT_ARRAY_READY_FLAG      5
`define NFH_ID_ADDR_MAIN   8'h00
`define NFH_ID_ADDR_ONFI   8'h20
`define NFH_ID_SIG         32'h49464E4F
`define NFH_ID_DIE_MSB     17
`define NFH_ID_DIE_LSB     16
`define NFH_ID_DIE_TWO     2'b01
`define NFH_ID_CACHE_BIT   23
`define NFH_PLANE_BIT      22
`define NFH_MAX_BYTES      3'h5

`endif

// ==== nfh_pkg.sv ====
// Purpose: Types and decode helpers of the NAND host sequencer.
// Assumes: nfh_params.svh holds the opcodes and the timer width.
// Notes:   Opcode classes are shared by the checks and the tracking.
`include "nfh_params.svh"

package nfh_pkg;

	// ==========================================================
	// Types
	typedef enum logic [11:0]
	{
		S_BOOT = 12'h001,
		S_PWR  = 12'h002,
		S_IDLE = 12'h004,
		S_CMD  = 12'h008,
		S_ADDR = 12'h010,
		S_CMD2 = 12'h020,
		S_TAIL = 12'h040,
		S_WB   = 12'h080,
		S_BUSY = 12'h100,
		S_GAP  = 12'h200,
		S_READ = 12'h400,
		S_DONE = 12'h800
	} nfh_state_type;

	typedef struct packed {
		nfh_state_type st;
		logic [1:0]    ph;
		logic [2:0]    idx;
		logic [7:0]    opc1;
		logic [2:0]    naddr;
		logic [39:0]   addr;
		logic [7:0]    opc2;
		logic          use2;
		logic [2:0]    ndata;
		logic          waitrb;
		logic [1:0]    init;
		logic [39:0]   rdata;
		logic          booted;
		logic          first_done;
		logic          last_rd;
		logic          last_cp;
		logic          two_pl;
		logic          mv_valid;
		logic          mv_plane;
		logic          otp;
		logic [7:0]    status;
		logic          ce_n;
		logic          cle;
		logic          ale;
		logic          we_n;
		logic          re_n;
		logic [7:0]    dq;
		logic          dq_oe;
		logic          wp_n;
		logic          ready;
		logic          done;
		logic          refused;
		logic          rst_tmo;
		logic          init_fault;
		logic          onfi_ok;
		logic          two_die;
		logic          cache_prog;
	} nfh_host_type;

	typedef struct packed {
		logic [`NFH_TMR_W-1:0] count;
		logic                  expired;
	} nfh_tmr_type;

	// ==========================================================
	// Helpers
	function automatic nfh_host_type nfh_host_rst();
		nfh_host_type x;
		x = '0;
		x.st = S_BOOT;
		x.ce_n = 1'b1;
		x.we_n = 1'b1;
		x.re_n = 1'b1;
		return x;
	endfunction

	function automatic logic nfh_naddr_ok(logic [7:0] op, logic [2:0] n);
		case (op)
			`NFH_OP_RESET, `NFH_OP_STATUS, `NFH_OP_CACHE_SEQ,
			`NFH_OP_CACHE_LAST:
				return n == 3'h0;
			`NFH_OP_READ:
				return n == 3'h0 || n == 3'h5;
			`NFH_OP_PROG, `NFH_OP_RAND_RD2:
				return n == 3'h5;
			`NFH_OP_RAND_IN:
				return n == 3'h2 || n == 3'h5;
			`NFH_OP_RAND_RD:
				return n == 3'h2;
			`NFH_OP_ERASE, `NFH_OP_STATUS_ENH, `NFH_OP_UNLOCK_LO,
			`NFH_OP_UNLOCK_HI, `NFH_OP_LOCK_RD:
				return n == 3'h3;
			`NFH_OP_READ_ID, `NFH_OP_PARAM, `NFH_OP_UID,
			`NFH_OP_GET_FEAT, `NFH_OP_SET_FEAT:
				return n == 3'h1;
			default:
				return 1'b1;
		endcase
	endfunction

	function automatic logic nfh_is_id_class(logic [7:0] op);
		return op == `NFH_OP_READ_ID || op == `NFH_OP_PARAM ||
			op == `NFH_OP_UID || op == `NFH_OP_GET_FEAT ||
			op == `NFH_OP_SET_FEAT;
	endfunction

	function automatic logic nfh_is_status(logic [7:0] op);
		return op == `NFH_OP_STATUS || op == `NFH_OP_STATUS_ENH;
	endfunction

	function automatic logic nfh_is_cache_rd(logic [7:0] op1,
		logic [7:0] op2, logic use2);
		return op1 == `NFH_OP_CACHE_SEQ || op1 == `NFH_OP_CACHE_LAST ||
			(use2 && op2 == `NFH_OP_CACHE_SEQ);
	endfunction

	function automatic nfh_host_type nfh_put_byte(nfh_host_type x,
		nfh_state_type st, logic cle, logic ale, logic [7:0] b);
		nfh_host_type y;
		y = x;
		y.st = st;
		y.ce_n = 1'b0;
		y.cle = cle;
		y.ale = ale;
		y.dq = b;
		y.dq_oe = 1'b1;
		y.we_n = 1'b0;
		y.ph = 2'h0;
		return y;
	endfunction

endpackage

// ==== nfh_timer.sv ====
// Purpose: Down counter for power-up, busy and turnaround waits.
// Assumes: value_i is at least one.
// Notes:   expired_o rises value_i cycles after load_i.
`include "nfh_params.svh"
module nfh_timer
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  load_i,
	input  wire logic [`NFH_TMR_W-1:0] value_i,
	output logic                       expired_o
);
	import nfh_pkg::*;

	nfh_tmr_type s;
	nfh_tmr_type next_s;

	// ==========================================================
	// Count
	always_comb
	begin
		next_s = s;
		if (load_i)
		begin
			next_s.count = value_i;
			next_s.expired = 1'b0;
		end
		else if (s.count > `NFH_TMR_W'(1))
			next_s.count = s.count - `NFH_TMR_W'(1);
		else
		begin
			next_s.count = '0;
			next_s.expired = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign expired_o = s.expired;
endmodule

// ==== nfh_host.sv ====
// Purpose: Host sequencer driving an asynchronous NAND target.
// Assumes: One target; user gives opcodes, address bytes, read count.
// Notes:   Data input phases of program are not generated.
`include "nfh_params.svh"

module nfh_host
#(
	parameter int P_POWERUP_CYC = `NFH_POWERUP_CYC,
	parameter int P_RST_CYC     = `NFH_RST_CYC
)
(
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	input  wire logic        REQ_I,
	input  wire logic [7:0]  OPC1_I,
	input  wire logic [2:0]  NADDR_I,
	input  wire logic [39:0] ADDR_I,
	input  wire logic [7:0]  OPC2_I,
	input  wire logic        USE_OPC2_I,
	input  wire logic [2:0]  NDATA_I,
	input  wire logic        WAIT_RB_I,
	input  wire logic        ECC_EN_I,
	input  wire logic        WP_REL_I,
	output logic             READY_O,
	output logic             DONE_O,
	output logic             REFUSED_O,
	output logic [39:0]      RDATA_O,
	output logic [7:0]       STATUS_O,
	output logic             INIT_FAULT_O,
	output logic             RST_TMO_O,
	output logic             ONFI_OK_O,
	output logic             ID_TWO_DIE_O,
	output logic             ID_CACHE_PROG_O,
	output logic             OTP_ARMED_O,
	output logic             NAND_CE_N_O,
	output logic             NAND_CLE_O,
	output logic             NAND_ALE_O,
	output logic             NAND_WE_N_O,
	output logic             NAND_READ_STROBE_N_O,
	output logic             NAND_WP_N_O,
	output logic [7:0]       NAND_DQ_O,
	output logic             NAND_DQ_OE_O,
	input  wire logic [7:0]  NAND_DQ_I,
	input  wire logic        NAND_RB_N_I
);
	import nfh_pkg::*;

	localparam nfh_host_type HOST_RST = nfh_host_rst();

	nfh_host_type          s;
	nfh_host_type          next_s;
	logic                  tmr_load;
	logic [`NFH_TMR_W-1:0] tmr_val;
	logic                  tmr_exp;
	logic                  req_bad;
	logic                  arr_busy;

	nfh_timer u_timer
	(
		.clk_i     (CLK_I),
		.rst_i     (RST_I),
		.load_i    (tmr_load),
		.value_i   (tmr_val),
		.expired_o (tmr_exp)
	);

	// ==========================================================
	// Next byte of a write burst
	function automatic nfh_host_type next_byte(nfh_host_type x);
		nfh_host_type y;
		logic [2:0]   nx;
		y = x;
		nx = x.idx + 3'h1;
		if (x.st == S_CMD && x.naddr != 3'h0)
		begin
			y = nfh_put_byte(x, S_ADDR, 1'b0, 1'b1, x.addr[7:0]);
			y.idx = 3'h0;
		end
		else if (x.st == S_ADDR && nx != x.naddr)
		begin
			y = nfh_put_byte(x, S_ADDR, 1'b0, 1'b1,
				x.addr[{nx, 3'b000} +: 8]);
			y.idx = nx;
		end
		else if (x.st != S_CMD2 && x.use2)
			y = nfh_put_byte(x, S_CMD2, 1'b1, 1'b0, x.opc2);
		else
		begin
			y.st = S_TAIL;
			y.cle = 1'b0;
			y.ale = 1'b0;
			y.dq_oe = 1'b0;
		end
		return y;
	endfunction

	// ==========================================================
	// Request screening
	assign arr_busy = s.status[`NFH_STAT_RDY] && !s.status[`NFH_STAT_ARRAY_READY_FLAG];
	assign req_bad =
		!nfh_naddr_ok(OPC1_I, NADDR_I) ||
		NDATA_I > `NFH_MAX_BYTES ||
		(ECC_EN_I && (nfh_is_cache_rd(OPC1_I, OPC2_I, USE_OPC2_I) ||
		OPC1_I == `NFH_OP_RAND_RD2 || (USE_OPC2_I &&
		(OPC2_I == `NFH_OP_PROG_CACHE || OPC2_I == `NFH_OP_PLANE_PROG ||
		OPC2_I == `NFH_OP_PLANE_ERASE || OPC2_I == `NFH_OP_READ)))) ||
		(OPC1_I == `NFH_OP_RAND_RD2 && !s.two_pl) ||
		(nfh_is_cache_rd(OPC1_I, OPC2_I, USE_OPC2_I) && arr_busy &&
		!s.last_rd) ||
		(USE_OPC2_I && OPC2_I == `NFH_OP_PROG_CACHE && arr_busy &&
		!s.last_cp) ||
		(OPC1_I == `NFH_OP_RAND_IN && USE_OPC2_I &&
		OPC2_I == `NFH_OP_PROG_GO && s.mv_valid &&
		ADDR_I[`NFH_PLANE_BIT] != s.mv_plane) ||
		(!NAND_RB_N_I && nfh_is_id_class(OPC1_I));

	// ==========================================================
	// Sequencer
	always_comb
	begin
		next_s = s;
		tmr_load = 1'b0;
		tmr_val = '0;
		next_s.done = 1'b0;
		next_s.refused = 1'b0;
		case (s.st)
			S_BOOT:
			begin
				tmr_load = 1'b1;
				tmr_val = `NFH_TMR_W'(P_POWERUP_CYC);
				next_s.st = S_PWR;
			end
			S_PWR:
			begin
				if (tmr_exp && NAND_RB_N_I)
				begin
					next_s.booted = 1'b1;
					next_s.opc1 = `NFH_OP_RESET;
					next_s.naddr = 3'h0;
					next_s.use2 = 1'b0;
					next_s.ndata = 3'h0;
					next_s.waitrb = 1'b1;
					next_s.init = 2'h1;
					next_s = nfh_put_byte(next_s, S_CMD, 1'b1, 1'b0,
						`NFH_OP_RESET);
				end
			end
			S_IDLE:
			begin
				next_s.wp_n = WP_REL_I;
				if (REQ_I && req_bad)
					next_s.refused = 1'b1;
				else if (REQ_I)
				begin
					next_s.ready = 1'b0;
					next_s.opc1 = OPC1_I;
					next_s.naddr = NADDR_I;
					next_s.addr = ADDR_I;
					next_s.opc2 = OPC2_I;
					next_s.use2 = USE_OPC2_I;
					next_s.ndata = NDATA_I;
					next_s.waitrb = WAIT_RB_I;
					next_s = nfh_put_byte(next_s, S_CMD, 1'b1, 1'b0, OPC1_I);
				end
			end
			S_CMD, S_ADDR, S_CMD2:
			begin
				next_s.ph = s.ph + 2'h1;
				if (s.ph == `NFH_PH_RISE)
					next_s.we_n = 1'b1;
				if (s.ph == `NFH_PH_LAST)
					next_s = next_byte(s);
			end
			S_TAIL:
			begin
				tmr_load = 1'b1;
				if (s.waitrb)
				begin
					tmr_val = `NFH_TMR_W'(`NFH_WB_CYC);
					next_s.st = S_WB;
				end
				else if (s.ndata != 3'h0)
				begin
					tmr_val = `NFH_TMR_W'(`NFH_WHR_CYC);
					next_s.st = S_GAP;
				end
				else
					next_s.st = S_DONE;
			end
			S_WB:
			begin
				if (tmr_exp)
				begin
					tmr_load = 1'b1;
					tmr_val = `NFH_TMR_W'(P_RST_CYC);
					next_s.st = S_BUSY;
				end
			end
			S_BUSY:
			begin
				if (NAND_RB_N_I && s.ndata != 3'h0)
				begin
					tmr_load = 1'b1;
					tmr_val = `NFH_TMR_W'(`NFH_WHR_CYC);
					next_s.st = S_GAP;
				end
				else if (NAND_RB_N_I)
					next_s.st = S_DONE;
				else if (tmr_exp && s.opc1 == `NFH_OP_RESET)
				begin
					next_s.rst_tmo = 1'b1;
					next_s.st = S_DONE;
				end
			end
			S_GAP:
			begin
				if (tmr_exp)
				begin
					next_s.st = S_READ;
					next_s.re_n = 1'b0;
					next_s.ph = 2'h0;
					next_s.idx = 3'h0;
				end
			end
			S_READ:
			begin
				next_s.ph = s.ph + 2'h1;
				if (s.ph == `NFH_PH_RISE)
				begin
					next_s.re_n = 1'b1;
					next_s.rdata[{s.idx, 3'b000} +: 8] = NAND_DQ_I;
				end
				if (s.ph == `NFH_PH_LAST && s.idx + 3'h1 == s.ndata)
					next_s.st = S_DONE;
				else if (s.ph == `NFH_PH_LAST)
				begin
					next_s.re_n = 1'b0;
					next_s.idx = s.idx + 3'h1;
				end
			end
			S_DONE:
			begin
				next_s.ce_n = 1'b1;
				next_s.st = S_IDLE;
				next_s.ready = 1'b1;
				if (s.opc1 == `NFH_OP_RESET)
				begin
					next_s.first_done = 1'b1;
					next_s.last_rd = 1'b0;
					next_s.last_cp = 1'b0;
					next_s.two_pl = 1'b0;
					next_s.mv_valid = 1'b0;
					next_s.otp = 1'b0;
				end
				else if (!nfh_is_status(s.opc1))
				begin
					next_s.last_rd = nfh_is_cache_rd(s.opc1, s.opc2, s.use2) ||
						(s.opc1 == `NFH_OP_READ && s.use2 &&
						s.opc2 == `NFH_OP_READ_GO);
					next_s.last_cp = s.use2 && s.opc2 == `NFH_OP_PROG_CACHE;
					next_s.two_pl = (s.use2 && s.opc2 == `NFH_OP_READ) ||
						(s.two_pl && (s.opc1 == `NFH_OP_READ ||
						s.opc1 == `NFH_OP_RAND_RD2 ||
						s.opc1 == `NFH_OP_RAND_RD));
				end
				if (s.use2 && s.opc2 == `NFH_OP_MOVE_RD)
				begin
					next_s.mv_valid = 1'b1;
					next_s.mv_plane = s.addr[`NFH_PLANE_BIT];
				end
				if (s.opc1 == `NFH_OP_SET_FEAT)
					next_s.otp = 1'b1;
				if (s.opc1 == `NFH_OP_STATUS && s.ndata != 3'h0)
					next_s.status = s.rdata[7:0];
				if (s.opc1 == `NFH_OP_READ_ID &&
					s.addr[7:0] == `NFH_ID_ADDR_ONFI)
					next_s.onfi_ok = s.rdata[31:0] == `NFH_ID_SIG;
				if (s.opc1 == `NFH_OP_READ_ID &&
					s.addr[7:0] == `NFH_ID_ADDR_MAIN &&
					s.ndata == `NFH_MAX_BYTES)
				begin
					next_s.two_die = s.rdata[`NFH_ID_DIE_MSB:`NFH_ID_DIE_LSB]
						== `NFH_ID_DIE_TWO;
					next_s.cache_prog = s.rdata[`NFH_ID_CACHE_BIT];
				end
				if (s.init == 2'h1)
				begin
					next_s.init = 2'h2;
					next_s.ready = 1'b0;
					next_s.opc1 = `NFH_OP_STATUS;
					next_s.ndata = 3'h1;
					next_s.waitrb = 1'b0;
					next_s = nfh_put_byte(next_s, S_CMD, 1'b1, 1'b0,
						`NFH_OP_STATUS);
				end
				else if (s.init == 2'h2)
				begin
					next_s.init = 2'h0;
					next_s.init_fault = s.rdata[7:0] != (s.wp_n ?
						`NFH_STAT_RST_WP1 : `NFH_STAT_RST_WP0);
				end
				else
					next_s.done = 1'b1;
			end
			default:
				next_s = HOST_RST;
		endcase
	end

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			s <= HOST_RST;
		else
			s <= next_s;
	end

	// ==========================================================
	// Outputs
	assign READY_O = s.ready;
	assign DONE_O = s.done;
	assign REFUSED_O = s.refused;
	assign RDATA_O = s.rdata;
	assign STATUS_O = s.status;
	assign INIT_FAULT_O = s.init_fault;
	assign RST_TMO_O = s.rst_tmo;
	assign ONFI_OK_O = s.onfi_ok;
	assign ID_TWO_DIE_O = s.two_die;
	assign ID_CACHE_PROG_O = s.cache_prog;
	assign OTP_ARMED_O = s.otp;
	assign NAND_CE_N_O = s.ce_n;
	assign NAND_CLE_O = s.cle;
	assign NAND_ALE_O = s.ale;
	assign NAND_WE_N_O = s.we_n;
	assign NAND_READ_STROBE_N_O = s.re_n;
	assign NAND_WP_N_O = s.wp_n;
	assign NAND_DQ_O = s.dq;
	assign NAND_DQ_OE_O = s.dq_oe;

	// ==========================================================
	// Checks
	chk_boot_wait: assert property
		(@(posedge CLK_I) disable iff (RST_I) $fell(s.ce_n) |-> s.booted)
		else $error("chip enable before power-up wait");
	chk_first_reset: assert property
		(@(posedge CLK_I) disable iff (RST_I)
		($fell(s.we_n) && s.cle && !s.first_done) |-> s.dq == `NFH_OP_RESET)
		else $error("first command is not reset");
	chk_id_busy: assert property
		(@(posedge CLK_I) disable iff (RST_I)
		(s.st == S_IDLE && REQ_I && OPC1_I == `NFH_OP_READ_ID &&
		!NAND_RB_N_I) |=> (REFUSED_O && s.st == S_IDLE))
		else $error("identifier read sent while busy");
	chk_busy_gate: assert property
		(@(posedge CLK_I) disable iff (RST_I)
		(s.st == S_IDLE && REQ_I && OPC1_I == `NFH_OP_SET_FEAT &&
		!NAND_RB_N_I) |=> REFUSED_O)
		else $error("feature command sent while busy");
	chk_ecc_cache: assert property
		(@(posedge CLK_I) disable iff (RST_I)
		(s.st == S_IDLE && REQ_I && ECC_EN_I &&
		OPC1_I == `NFH_OP_CACHE_SEQ) |=> REFUSED_O)
		else $error("cache read sent with ECC on");
	chk_cmd_latch: assert property
		(@(posedge CLK_I) disable iff (RST_I)
		!s.we_n |-> (s.re_n && !s.ce_n && !(s.cle && s.ale) && s.dq_oe))
		else $error("bad latch enables during write strobe");
	chk_we_width: assert property
		(@(posedge CLK_I) disable iff (RST_I)
		$fell(s.we_n) |-> !s.we_n [*2] ##1 s.we_n [*2])
		else $error("write strobe shape wrong");
	chk_read_strobe: assert property
		(@(posedge CLK_I) disable iff (RST_I)
		!s.re_n |-> (s.we_n && !s.cle && !s.ale && !s.ce_n && !s.dq_oe))
		else $error("read strobe with bad control lines");
	chk_busy_hold: assert property
		(@(posedge CLK_I) disable iff (RST_I)
		(s.st == S_BUSY && !NAND_RB_N_I && s.opc1 != `NFH_OP_RESET)
		|=> s.st == S_BUSY)
		else $error("left busy wait while line low");
	chk_rst_status: assert property
		(@(posedge CLK_I) disable iff (RST_I)
		(s.st == S_DONE && s.init == 2'h2) |=> INIT_FAULT_O ==
		($past(s.rdata[7:0]) != ($past(s.wp_n) ?
		`NFH_STAT_RST_WP1 : `NFH_STAT_RST_WP0)))
		else $error("reset status check wrong");
endmodule

// ==== nfh_dev_model.sv ====
// Purpose: Behavioural NAND target facing the host sequencer.
// Assumes: One die; strobes sampled on clk_i.
// Notes:   Busy times are short cycle counts.
module nfh_dev_model
#(
	parameter int         P_PWR = 60,
	parameter int         P_RST = 30,
	parameter int         P_BSY = 40,
	parameter logic [7:0] P_MFR = 8'h5A,
	parameter logic [7:0] P_DEV = 8'h3E
)
(
	input  wire logic       clk_i,
	input  wire logic       ce_n_i,
	input  wire logic       cle_i,
	input  wire logic       ale_i,
	input  wire logic       we_n_i,
	input  wire logic       re_n_i,
	input  wire logic       wp_n_i,
	input  wire logic [7:0] dq_i,
	output logic      [7:0] dq_o,
	output logic            rb_n_o,
	output logic            viol_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========
	// State
	logic [7:0] ob [0:7] = '{default: 8'h00};
	logic [7:0] cmd = 8'h00;
	logic [2:0] ix  = 3'h0;
	logic       pw  = 1'b1;
	logic       pr  = 1'b1;
	logic       fr  = 1'b1;
	logic       vi  = 1'b0;
	logic       cch = 1'b0;
	int         bsy = 0;
	int         pwr = P_PWR;
	logic       wr, rd, ok, ad;

	// ==========
	// Pins
	assign rb_n_o = !(bsy > 0 || pwr > 0);
	assign dq_o = ce_n_i ? ~ob[ix] : ob[ix];
	assign viol_o = vi;
	assign wr = !pw && we_n_i && !ce_n_i;
	assign rd = !pr && re_n_i && !ce_n_i && !cle_i && !ale_i;
	assign ok = bsy == 0 ||
		dq_i inside {8'hFF, 8'h70, 8'h78};
	assign ad = wr && ale_i && !cle_i && cmd == 8'h90;

	// ==========
	// Latching and busy time
	always @(posedge clk_i)
	begin
		pw <= we_n_i;
		pr <= re_n_i;
		if (pwr > 0)
			pwr <= pwr - 1;
		if (bsy > 0)
			bsy <= bsy - 1;
		if (rd)
			ix <= ix + 3'h1;
		if (wr && ((cle_i && ale_i) || !re_n_i || pwr > 0))
			vi <= 1'b1;
		if (wr && cle_i && !ale_i && ok)
		begin
			cmd <= dq_i;
			ix <= 3'h0;
			fr <= 1'b0;
			if (fr && dq_i != 8'hFF)
				vi <= 1'b1;
			if (dq_i == 8'hFF)
			begin
				bsy <= P_RST;
				ob <= '{default: 8'h00};
			end
			if (dq_i inside {8'h30, 8'h35, 8'h10, 8'hD0})
				bsy <= P_BSY;
			if (!(dq_i inside {8'h70, 8'h78}))
				cch <= dq_i inside {8'h31, 8'h3F, 8'h15};
			if (dq_i == 8'h70)
				ob[0] <= {wp_n_i, bsy == 0, bsy == 0 && !cch, 5'h00};
		end
		// Bytes stay until a reset command or the next identifier address; status 70h replaces byte 0
		if (ad && dq_i == 8'h00)
			ob <= '{0: P_MFR, 1: P_DEV, 2: 8'h91, default: 8'h01};
		if (ad && dq_i == 8'h20)
			ob <= '{8'h4F, 8'h4E, 8'h46, 8'h49, 8'h00, 8'h00, 8'h00, 8'h00};
	end
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench of the NAND host sequencer.
// Assumes: Scaled power-up and reset counts.
// Notes:   Each scenario task judges its own results.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========
	// Signals
	localparam logic [7:0] MFR = 8'h5A; // Arbitrary value
	localparam logic [7:0] DEV = 8'h3E; // Arbitrary value
	logic        clk = 1'b0, rst = 1'b1, req = 1'b0, u2 = 1'b0;
	logic        wrb = 1'b0, ecc = 1'b0, wp = 1'b0;
	logic [7:0]  o1 = 8'h00, o2 = 8'h00, stat, dqo, dqd, dqi;
	logic [2:0]  na = 3'h0, nd = 3'h0;
	logic [39:0] adr = 40'h0, rdat;
	logic        rdy, done, refd, ifl, tmo, onfi, two, cpg, otp;
	logic        ce_n, cle, ale, we_n, re_n, wp_n, oe, rb_n, viol;
	int          error_cnt = 0;
	int          cmp_count = 0;

	assign dqi = oe ? dqo : dqd;
	initial
		forever #5 clk = ~clk;

	nfh_host #(.P_POWERUP_CYC(20), .P_RST_CYC(50)) dut (
		.CLK_I(clk), .RST_I(rst), .REQ_I(req), .OPC1_I(o1),
		.NADDR_I(na), .ADDR_I(adr), .OPC2_I(o2), .USE_OPC2_I(u2),
		.NDATA_I(nd), .WAIT_RB_I(wrb), .ECC_EN_I(ecc), .WP_REL_I(wp),
		.READY_O(rdy), .DONE_O(done), .REFUSED_O(refd), .RDATA_O(rdat),
		.STATUS_O(stat), .INIT_FAULT_O(ifl), .RST_TMO_O(tmo),
		.ONFI_OK_O(onfi), .ID_TWO_DIE_O(two), .ID_CACHE_PROG_O(cpg),
		.OTP_ARMED_O(otp), .NAND_CE_N_O(ce_n), .NAND_CLE_O(cle),
		.NAND_ALE_O(ale), .NAND_WE_N_O(we_n),
		.NAND_READ_STROBE_N_O(re_n), .NAND_WP_N_O(wp_n),
		.NAND_DQ_O(dqo), .NAND_DQ_OE_O(oe), .NAND_DQ_I(dqi),
		.NAND_RB_N_I(rb_n));

	nfh_dev_model #(.P_MFR(MFR), .P_DEV(DEV)) dev (
		.clk_i(clk), .ce_n_i(ce_n), .cle_i(cle), .ale_i(ale),
		.we_n_i(we_n), .re_n_i(re_n), .wp_n_i(wp_n), .dq_i(dqi),
		.dq_o(dqd), .rb_n_o(rb_n), .viol_o(viol));

	// ==========
	// Helpers
	task automatic check(input logic [39:0] s, input logic [39:0] x);
		cmp_count++;
		if (s !== x)
		begin
			error_cnt++;
			$display("CHECK FAILED %0t seen %h exp %h", $time, s, x);
		end
	endtask

	task automatic end_of_test();
		if (error_cnt == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic step(inout int k);
		@(posedge clk);
		#1;
		k++;
		if (k > 3000)
		begin
			error_cnt++;
			end_of_test();
		end
	endtask

	task automatic job(input logic [7:0] c1, input logic [2:0] n,
		input logic [39:0] a, input logic [7:0] c2, input logic [2:0] d,
		input logic w, input logic e);
		int k;
		k = 0;
		while (rdy !== 1'b1)
			step(k);
		{o1, na, adr, o2, u2, nd, wrb} = {c1, n, a, c2, c2 != 8'h00, d, w};
		req = 1'b1;
		step(k);
		req = 1'b0;
		while (done !== 1'b1 && refd !== 1'b1)
			step(k);
		check(refd, e);
	endtask

	// ==========
	// Scenarios
	task automatic s_init();
		job(8'h70, 3'h0, 40'h0, 8'h00, 3'h1, 1'b0, 1'b0);
		check(stat, 8'h60);
		check({ifl, tmo}, 2'b00);
		check(viol, 1'b0);
	endtask

	task automatic s_id();
		job(8'h90, 3'h1, 40'h0, 8'h00, 3'h5, 1'b0, 1'b0);
		check(rdat, {8'h01, 8'h01, 8'h91, DEV, MFR});
		check({two, cpg}, 2'b11);
		job(8'h90, 3'h1, 40'h20, 8'h00, 3'h4, 1'b0, 1'b0);
		check(rdat, 40'h0149464E4F);
		check(onfi, 1'b1);
	endtask

	task automatic s_ref();
		logic [7:0] ops [0:5] = '{8'hFF, 8'h00, 8'h80, 8'h05, 8'h60, 8'h90};
		logic [2:0] ns [0:5] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h2, 3'h0};
		for (int i = 0; i < 6; i++)
			job(ops[i], ns[i], 40'h0, 8'h00, 3'h0, 1'b0, 1'b1);
		ecc = 1'b1;
		job(8'h31, 3'h0, 40'h0, 8'h00, 3'h0, 1'b0, 1'b1);
		job(8'h80, 3'h5, 40'h0, 8'h11, 3'h0, 1'b0, 1'b1);
		ecc = 1'b0;
		job(8'h80, 3'h5, 40'h0, 8'h11, 3'h0, 1'b0, 1'b0);
		job(8'h06, 3'h5, 40'h0, 8'hE0, 3'h0, 1'b0, 1'b1);
	endtask

	task automatic s_busy();
		job(8'h00, 3'h5, 40'h0, 8'h30, 3'h0, 1'b0, 1'b0);
		job(8'h90, 3'h1, 40'h0, 8'h00, 3'h5, 1'b0, 1'b1);
		job(8'h70, 3'h0, 40'h0, 8'h00, 3'h1, 1'b0, 1'b0);
		check(stat[6], 1'b0);
		job(8'h60, 3'h3, 40'h0, 8'hD0, 3'h0, 1'b0, 1'b0);
		job(8'hEF, 3'h1, 40'h0, 8'h00, 3'h0, 1'b1, 1'b1);
		job(8'hFF, 3'h0, 40'h0, 8'h00, 3'h0, 1'b1, 1'b0);
		check(tmo, 1'b0);
	endtask

	task automatic s_otp();
		job(8'hEF, 3'h1, 40'h0, 8'h00, 3'h0, 1'b0, 1'b0);
		check(otp, 1'b1);
		wp = 1'b1;
		job(8'hFF, 3'h0, 40'h0, 8'h00, 3'h0, 1'b1, 1'b0);
		check(otp, 1'b0);
		job(8'h70, 3'h0, 40'h0, 8'h00, 3'h1, 1'b0, 1'b0);
		check(stat, 8'hE0);
	endtask

	task automatic s_move();
		job(8'h00, 3'h5, 40'h0, 8'h35, 3'h0, 1'b1, 1'b0);
		job(8'h85, 3'h5, 40'h400000, 8'h10, 3'h0, 1'b0, 1'b1);
		job(8'h85, 3'h5, 40'h0, 8'h10, 3'h0, 1'b1, 1'b0);
	endtask

	task automatic s_cache();
		job(8'h00, 3'h5, 40'h0, 8'h30, 3'h0, 1'b1, 1'b0);
		job(8'h31, 3'h0, 40'h0, 8'h00, 3'h0, 1'b1, 1'b0);
		job(8'h70, 3'h0, 40'h0, 8'h00, 3'h1, 1'b0, 1'b0);
		check(stat, 8'hC0);
		job(8'h3F, 3'h0, 40'h0, 8'h00, 3'h0, 1'b1, 1'b0);
		job(8'h80, 3'h5, 40'h0, 8'h15, 3'h0, 1'b0, 1'b1);
		job(8'h85, 3'h2, 40'h0, 8'h00, 3'h0, 1'b0, 1'b0);
		job(8'h31, 3'h0, 40'h0, 8'h00, 3'h0, 1'b0, 1'b1);
	endtask

	initial
	begin
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		s_init();
		s_id();
		s_ref();
		s_busy();
		s_otp();
		s_move();
		s_cache();
		check(viol, 1'b0);
		end_of_test();
	end
endmodule
